// File: verilog/dcp_map.vh
`ifndef DCP_MAP_VH
`define DCP_MAP_VH
// Counter widths and reset values
`define DCP_SYS_W        13
`define DCP_WATCH_W      5
`define DCP_SYS_RST      13'h0000
`define DCP_WATCH_RST    5'h00
// Subclock pre-divide ratio (divide by 4 as two-bit counter)
`define DCP_SUB_DIV_W    2
// Medium-speed oscillator divide select codes: /16 /32 /64 /128
`define DCP_MED_DIV16    2'h0
`define DCP_MED_DIV32    2'h1
`define DCP_MED_DIV64    2'h2
`define DCP_MED_DIV128   2'h3
`define DCP_OSC_DIV_W    7
// Medium-speed sleep peripheral divide codes: /8 /16 /32 /64
`define DCP_SLP_DIV8     2'h0
`define DCP_SLP_DIV16    2'h1
`define DCP_SLP_DIV32    2'h2
`define DCP_SLP_DIV64    2'h3
// Operating mode codes
`define DCP_MODE_W       3
`define DCP_M_ACT_HI     3'h0
`define DCP_M_ACT_MED    3'h1
`define DCP_M_SLP_HI     3'h2
`define DCP_M_SLP_MED    3'h3
`define DCP_M_SUBACT     3'h4
`define DCP_M_SUBSLP     3'h5
`define DCP_M_WATCH      3'h6
`define DCP_M_STBY       3'h7
`endif

// File: verilog/dcp_prescalers.v
// Functional notes
// - 13-bit system prescaler counts every system tick
// - Reset clears system prescaler, counts after release
// - Standby/watch/sub modes hold system prescaler cleared
// - No processor access path to counter
// - Taps shared; each peripheral selects own tap
// - Active medium-speed feeds oscillator /16,/32,/64,/128
// - 5-bit watch prescaler clocked by subclock/4
// - Reset clears watch prescaler, counts after release
// - Watch prescaler runs in all low-power modes
// - Timer-A write with both reset bits set clears watch prescaler
// - Watch taps offered as timer A source
// - Medium sleep halts CPU, peripherals at /8../64
// - Subactive runs CPU on subclock, system stopped
// - Standby stops CPU and all peripherals
// - Module standby stops selected peripherals only
// - System taps at divide 2 through 8192
`timescale 1ns/1ps
`include "dcp_map.vh"

module dcp_prescalers #(
    parameter NUM_PERIPH = 8
) (
    mclk,
    srst,
    sub_osc_in,
    op_mode,
    med_osc_sel,
    med_sleep_sel,
    timer_a_ctl_bit3,
    timer_a_ctl_bit2,
    timer_a_wr,
    module_stby,
    sys_tick_en,
    sys_tap_en,
    watch_tap_en,
    cpu_clk_en,
    cpu_on_sub,
    periph_clk_en,
    system_prescaler_run
);
    input  wire                          mclk;
    input  wire                          srst;
    input  wire                          sub_osc_in;
    input  wire [`DCP_MODE_W-1:0]        op_mode;
    input  wire [1:0]                    med_osc_sel;
    input  wire [1:0]                    med_sleep_sel;
    input  wire                          timer_a_ctl_bit3;
    input  wire                          timer_a_ctl_bit2;
    input  wire                          timer_a_wr;
    input  wire [NUM_PERIPH-1:0]         module_stby;
    output reg                           sys_tick_en;
    output reg  [`DCP_SYS_W-1:0]         sys_tap_en;
    output reg  [`DCP_WATCH_W-1:0]       watch_tap_en;
    output reg                           cpu_clk_en;
    output reg                           cpu_on_sub;
    output reg  [NUM_PERIPH-1:0]         periph_clk_en;
    output reg                           system_prescaler_run;

    // =====================================================
    // Mode decode
    // =====================================================
    wire sys_stop = (op_mode == `DCP_M_STBY)   ||
                    (op_mode == `DCP_M_WATCH)  ||
                    (op_mode == `DCP_M_SUBACT) ||
                    (op_mode == `DCP_M_SUBSLP);
    // Only active medium speed slows the prescaler feed; medium
    // sleep keeps full rate so its /8../64 taps track the system clock
    wire med_mode = (op_mode == `DCP_M_ACT_MED);

    // =====================================================
    // Subclock synchroniser and edge detect
    // =====================================================
    reg sub_meta_r;
    reg sub_sync_r;
    reg sub_prev_r;
    always @(posedge mclk)
    begin
        if (srst)
        begin
            sub_meta_r <= 1'b0;
            sub_sync_r <= 1'b0;
            sub_prev_r <= 1'b0;
        end
        else
        begin
            sub_meta_r <= sub_osc_in;
            sub_sync_r <= sub_meta_r;
            sub_prev_r <= sub_sync_r;
        end
    end
    // Rising edge only from the second stage onward
    wire sub_rise = sub_sync_r & ~sub_prev_r;

    // =====================================================
    // Medium-speed oscillator divider
    // =====================================================
    reg [`DCP_OSC_DIV_W-1:0] osc_div_r;
    reg [`DCP_OSC_DIV_W-1:0] osc_mask;
    always @*
    begin
        case (med_osc_sel)
            `DCP_MED_DIV16:  osc_mask = 7'h0F;
            `DCP_MED_DIV32:  osc_mask = 7'h1F;
            `DCP_MED_DIV64:  osc_mask = 7'h3F;
            `DCP_MED_DIV128: osc_mask = 7'h7F;
            default:         osc_mask = 7'h0F;
        endcase
    end
    always @(posedge mclk)
    begin
        if (srst || !med_mode)
            osc_div_r <= 7'h00;
        else
            osc_div_r <= osc_div_r + 7'h01;
    end
    // High speed: every cycle; medium: one per selected period
    wire sys_tick = !sys_stop &&
                    (!med_mode || ((osc_div_r & osc_mask) == osc_mask));

    // =====================================================
    // System prescaler: no processor path exists
    // =====================================================
    reg  [`DCP_SYS_W-1:0] system_prescaler_r;
    wire [`DCP_SYS_W-1:0] system_prescaler_nxt =
        system_prescaler_r + 13'h0001;
    always @(posedge mclk)
    begin
        if (srst)
            system_prescaler_r <= `DCP_SYS_RST;
        else if (sys_stop)
            system_prescaler_r <= `DCP_SYS_RST;
        else if (sys_tick)
            system_prescaler_r <= system_prescaler_nxt;
    end

    // =====================================================
    // Subclock /4 and watch prescaler
    // =====================================================
    reg [`DCP_SUB_DIV_W-1:0] sub_div_r;
    reg [`DCP_WATCH_W-1:0]   watch_prescaler_r;
    wire watch_tick = sub_rise && (sub_div_r == 2'h3);
    wire watch_clr  = timer_a_wr && timer_a_ctl_bit3 &&
                      timer_a_ctl_bit2;
    always @(posedge mclk)
    begin
        if (srst)
            sub_div_r <= 2'h0;
        else if (sub_rise)
            sub_div_r <= sub_div_r + 2'h1;
    end
    // Keeps counting regardless of op_mode while subclock toggles
    always @(posedge mclk)
    begin
        if (srst)
            watch_prescaler_r <= `DCP_WATCH_RST;
        else if (watch_clr)
            watch_prescaler_r <= `DCP_WATCH_RST;
        else if (watch_tick)
            watch_prescaler_r <= watch_prescaler_r + 5'h01;
    end

    // =====================================================
    // Tap strobes: one pulse per rising bit of each stage
    // =====================================================
    wire [`DCP_SYS_W-1:0]   sys_rise = ~system_prescaler_r &
                                       system_prescaler_nxt;
    wire [`DCP_WATCH_W-1:0] w_nxt    = watch_prescaler_r + 5'h01;
    wire [`DCP_WATCH_W-1:0] w_rise   = ~watch_prescaler_r & w_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < `DCP_SYS_W; gi = gi + 1)
        begin : g_sys_tap
            // Bit gi strobe gives divide 2^(gi+1)
            always @(posedge mclk)
            begin
                if (srst)
                    sys_tap_en[gi] <= 1'b0;
                else
                    sys_tap_en[gi] <= sys_tick && sys_rise[gi];
            end
        end
        for (gi = 0; gi < `DCP_WATCH_W; gi = gi + 1)
        begin : g_w_tap
            always @(posedge mclk)
            begin
                if (srst)
                    watch_tap_en[gi] <= 1'b0;
                else
                    watch_tap_en[gi] <= watch_tick && !watch_clr &&
                                        w_rise[gi];
            end
        end
    endgenerate

    // =====================================================
    // Peripheral and CPU clock gating by mode
    // =====================================================
    reg [1:0] slp_cnt_sel;
    always @*
    begin
        case (med_sleep_sel)
            `DCP_SLP_DIV8:  slp_cnt_sel = 2'h0;
            `DCP_SLP_DIV16: slp_cnt_sel = 2'h1;
            `DCP_SLP_DIV32: slp_cnt_sel = 2'h2;
            `DCP_SLP_DIV64: slp_cnt_sel = 2'h3;
            default:        slp_cnt_sel = 2'h0;
        endcase
    end
    // Taps 2..5 are /8../64 of the system clock
    wire slp_tick = sys_tick && sys_rise[{1'b0, slp_cnt_sel} + 3'h2];
    reg periph_base;
    always @*
    begin
        case (op_mode)
            `DCP_M_SLP_MED: periph_base = slp_tick;
            `DCP_M_STBY:    periph_base = 1'b0;
            `DCP_M_WATCH,
            `DCP_M_SUBACT,
            `DCP_M_SUBSLP:  periph_base = watch_tick;
            default:        periph_base = sys_tick;
        endcase
    end
    always @(posedge mclk)
    begin
        if (srst)
        begin
            sys_tick_en          <= 1'b0;
            cpu_clk_en           <= 1'b0;
            cpu_on_sub           <= 1'b0;
            periph_clk_en        <= {NUM_PERIPH{1'b0}};
            system_prescaler_run <= 1'b0;
        end
        else
        begin
            sys_tick_en <= sys_tick;
            // CPU halted in every sleep, watch and standby mode
            case (op_mode)
                `DCP_M_ACT_HI,
                `DCP_M_ACT_MED: cpu_clk_en <= sys_tick;
                `DCP_M_SUBACT:  cpu_clk_en <= watch_tick;
                default:        cpu_clk_en <= 1'b0;
            endcase
            cpu_on_sub <= (op_mode == `DCP_M_SUBACT);
            periph_clk_en <= {NUM_PERIPH{periph_base}} &
                             ~module_stby;
            system_prescaler_run <= !sys_stop;
        end
    end
endmodule

// File: tb/dcp_prescalers_assertions.sv
`timescale 1ns/1ps
// ==========================================
// Port checks on the prescaler block
module dcp_prescalers_chk #(
    parameter NUM_PERIPH = 8
) (
    input wire                  mclk,
    input wire                  srst,
    input wire [2:0]            op_mode,
    input wire                  timer_a_ctl_bit3,
    input wire                  timer_a_ctl_bit2,
    input wire                  timer_a_wr,
    input wire [NUM_PERIPH-1:0] module_stby,
    input wire                  sys_tick_en,
    input wire [12:0]           sys_tap_en,
    input wire [4:0]            watch_tap_en,
    input wire                  cpu_clk_en,
    input wire                  cpu_on_sub,
    input wire [NUM_PERIPH-1:0] periph_clk_en,
    input wire                  system_prescaler_run
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    hi_tick_a: assert property (op_mode == 3'h0 |=> sys_tick_en)
        else $error("no tick in fast mode");
    tap_onehot_a: assert property (sys_tap_en != 13'h0000 |->
        sys_tick_en && $onehot(sys_tap_en))
        else $error("bad system tap pattern");
    stop_hold_a: assert property (op_mode[2] |=>
        !system_prescaler_run && !sys_tick_en)
        else $error("system count runs in low power");
    run_level_a: assert property (!op_mode[2] |=> system_prescaler_run)
        else $error("system count stopped when active");
    watch_clr_a: assert property (timer_a_wr && timer_a_ctl_bit3
        && timer_a_ctl_bit2 |=> watch_tap_en == 5'h00
        ##1 watch_tap_en[4:1] == 4'h0)
        else $error("watch clear not honoured");
    watch_hot_a: assert property ($onehot0(watch_tap_en))
        else $error("bad watch tap pattern");
    sub_cpu_a: assert property (op_mode == 3'h4 |=> cpu_on_sub)
        else $error("cpu not on subclock");
    stby_halt_a: assert property (op_mode == 3'h7 |=>
        !cpu_clk_en && periph_clk_en == '0)
        else $error("activity in standby");
    mstby_gate_a: assert property (1'b1 |=>
        (periph_clk_en & $past(module_stby)) == '0)
        else $error("standby module clocked");
    slp_halt_a: assert property (op_mode == 3'h3 |=> !cpu_clk_en)
        else $error("cpu runs in sleep");
    cover property (sys_tap_en[12]);
    cover property (watch_tap_en[4]);
    cover property (op_mode == 3'h1 && sys_tick_en);
endmodule
bind dcp_prescalers dcp_prescalers_chk #(.NUM_PERIPH(NUM_PERIPH)) u_chk (
    .mclk                 (mclk),
    .srst                 (srst),
    .op_mode              (op_mode),
    .timer_a_ctl_bit3     (timer_a_ctl_bit3),
    .timer_a_ctl_bit2     (timer_a_ctl_bit2),
    .timer_a_wr           (timer_a_wr),
    .module_stby          (module_stby),
    .sys_tick_en          (sys_tick_en),
    .sys_tap_en           (sys_tap_en),
    .watch_tap_en         (watch_tap_en),
    .cpu_clk_en           (cpu_clk_en),
    .cpu_on_sub           (cpu_on_sub),
    .periph_clk_en        (periph_clk_en),
    .system_prescaler_run (system_prescaler_run)
);

// File: tb/dcp_subclk_model.sv
`timescale 1ns/1ps
// ==========================================
// Subclock crystal feeding the watch side
module dcp_subclk_model #(
    parameter HALF_NS = 103
) (
    input wire run,
    output reg sub_clk
);
    // Odd half period keeps it out of phase with mclk
    initial sub_clk = 1'b0;
    always
    begin
        #(HALF_NS);
        sub_clk = run ? ~sub_clk : 1'b0;
    end
endmodule

// File: tb/dcp_prescalers_tb_top.sv
`timescale 1ns/1ps
module dcp_prescalers_tb_top;
    reg         mclk;
    reg         srst;
    reg  [2:0]  op_mode;
    reg  [1:0]  med_osc_sel;
    reg  [1:0]  med_sleep_sel;
    reg         timer_a_ctl_bit3;
    reg         timer_a_ctl_bit2;
    reg         timer_a_wr;
    reg  [7:0]  module_stby;
    reg         sub_run;
    wire        sub_osc_in;
    wire        sys_tick_en;
    wire        cpu_clk_en;
    wire        cpu_on_sub;
    wire        system_prescaler_run;
    wire [12:0] sys_tap_en;
    wire [4:0]  watch_tap_en;
    wire [7:0]  periph_clk_en;
    int         err_total;
    int         samples_checked;
    int         c;
    dcp_prescalers uut (
        .mclk                 (mclk),
        .srst                 (srst),
        .sub_osc_in           (sub_osc_in),
        .op_mode              (op_mode),
        .med_osc_sel          (med_osc_sel),
        .med_sleep_sel        (med_sleep_sel),
        .timer_a_ctl_bit3     (timer_a_ctl_bit3),
        .timer_a_ctl_bit2     (timer_a_ctl_bit2),
        .timer_a_wr           (timer_a_wr),
        .module_stby          (module_stby),
        .sys_tick_en          (sys_tick_en),
        .sys_tap_en           (sys_tap_en),
        .watch_tap_en         (watch_tap_en),
        .cpu_clk_en           (cpu_clk_en),
        .cpu_on_sub           (cpu_on_sub),
        .periph_clk_en        (periph_clk_en),
        .system_prescaler_run (system_prescaler_run)
    );
    dcp_subclk_model u_sub (.run(sub_run), .sub_clk(sub_osc_in));
    // ==========================================
    // Helpers
    task chk(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Inputs move 1 ns after the edge, outputs settled by then
    task step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    function logic pick(input int s);
        return s == 0 ? sys_tick_en : s == 1 ? periph_clk_en[0]
            : s == 2 ? watch_tap_en[0] : |watch_tap_en;
    endfunction
    // Bounded wait for a strobe; a hang ends the run
    task gap(input int s, output int n);
        n = 0;
        do
        begin
            step(1);
            n++;
        end while (!pick(s) && n < 3000);
        if (n >= 3000)
        begin
            err_total++;
            complete_run;
        end
    endtask
    // ==========================================
    // Scenarios
    task run_fast;
        int cnt [13];
        int t;
        t = 0;
        foreach (cnt[k]) cnt[k] = 0;
        gap(0, c);
        chk("first tap", sys_tap_en, 13'h0001);
        step(1);
        chk("second tap", sys_tap_en, 13'h0002);
        // Full window spans a wrap, so a stuck top stage shows
        repeat (16384)
        begin
            step(1);
            t += sys_tick_en;
            foreach (cnt[k]) cnt[k] += sys_tap_en[k];
        end
        chk("ticks", t, 16384);
        // Bit k pulses once per 2^(k+1) ticks
        foreach (cnt[k]) chk("tap count", cnt[k], 32'd1 << (13 - k));
    endtask
    task run_div(input logic [2:0] m, input int s0, input int base);
        op_mode = m;
        module_stby = 8'h80;
        for (int s = 0; s < 4; s++)
        begin
            med_osc_sel = s[1:0];
            med_sleep_sel = s[1:0];
            gap(s0, c);
            gap(s0, c);
            chk("divide gap", c, base << s);
            if (s0 == 1)
                chk("gated module", periph_clk_en[7], 1'b0);
        end
    endtask
    task run_watch;
        logic [4:0] exp [4];
        exp = '{5'h01, 5'h02, 5'h01, 5'h04};
        sub_run = 1'b1;
        op_mode = 3'h7;
        gap(2, c);
        gap(2, c);
        chk("watch gap", c >= 163 && c <= 166, 1'b1);
        chk("stopped run", system_prescaler_run, 1'b0);
        timer_a_ctl_bit3 = 1'b1;
        timer_a_ctl_bit2 = 1'b1;
        timer_a_wr = 1'b1;
        step(1);
        timer_a_wr = 1'b0;
        op_mode = 3'h4;
        foreach (exp[k])
        begin
            gap(3, c);
            chk("watch tap", watch_tap_en, exp[k]);
            chk("sub cpu clock", cpu_clk_en, 1'b1);
            chk("sub periph", periph_clk_en, 8'h7F);
        end
        chk("sub cpu", cpu_on_sub, 1'b1);
    endtask
    // Mid-run reset restarts the watch count from zero
    task run_reset;
        srst = 1'b1;
        step(4);
        chk("reset taps", {sys_tap_en, watch_tap_en}, 18'h00000);
        chk("reset periph", periph_clk_en, 8'h00);
        srst = 1'b0;
        gap(3, c);
        chk("restart tap", watch_tap_en, 5'h01);
        gap(3, c);
        chk("restart tap", watch_tap_en, 5'h02);
    endtask
    // ==========================================
    // Clock and main sequence
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        {srst, sub_run, timer_a_wr} = 3'b100;
        {timer_a_ctl_bit3, timer_a_ctl_bit2} = 2'b00;
        {op_mode, med_osc_sel, med_sleep_sel} = 7'h00;
        module_stby = 8'h00;
        err_total = 0;
        samples_checked = 0;
        step(8);
        srst = 1'b0;
        run_fast;
        run_div(3'h1, 0, 16);
        run_div(3'h3, 1, 8);
        run_watch;
        run_reset;
        complete_run;
    end
endmodule
